/* bench/vlsc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module vlsc_monitor
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWrite,
   input wire logic [31:0] encoderPosition,
   input wire logic [31:0] ramp_actual_position,
   input wire logic        stopLeft,
   input wire logic        stopRight
);
   reg signed [31:0] lim0, lim1;
   reg               src;
   wire signed [31:0] pos = src ? encoderPosition : ramp_actual_position;
   wire               atL = pos <= lim0, atR = pos >= lim1;
   always @(posedge clk)
      if (srst) {src, lim1, lim0} <= 65'h0;
      else if (regWrite && regAddr == 8'h3e) lim0 <= regWdata;
      else if (regWrite && regAddr == 8'h3f) lim1 <= regWdata;
      else if (regWrite && regAddr == 8'h40) src <= regWdata[0];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   enc_left_a:
      assert property (src |=> stopLeft == $past(atL)) else $error("left");
   ramp_left_a:
      assert property (!src |=> stopLeft == $past(atL)) else $error("left");
   enc_right_a:
      assert property (src |=> stopRight == $past(atR)) else $error("right");
   ramp_right_a:
      assert property (!src |=> stopRight == $past(atR)) else $error("right");
   signed_cmp_a:
      assert property (pos[31] && !lim1[31] |=> !stopRight)
         else $error("sign");
   signed_left_a:
      assert property (!pos[31] && lim0[31] |=> !stopLeft)
         else $error("sign left");
   stop_clear_a:
      assert property (stopLeft && !atL |=> !stopLeft) else $error("clear");
   cover property (stopLeft && stopRight);
   cover property (src && stopRight);
   cover property (!src && stopLeft);
endmodule // vlsc_monitor
bind vlsc_virtual_limit_switch_compare vlsc_monitor mon (.clk, .srst,
   .regAddr, .regWdata, .regWrite, .encoderPosition, .ramp_actual_position,
   .stopLeft, .stopRight);
`default_nettype wire

/* bench/vlsc_virtual_limit_switch_compare_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module vlsc_virtual_limit_switch_compare_bench;
   logic        clk = 0, srst = 1, regWrite = 0, regRead = 0;
   logic        stopLeft, stopRight;
   logic [7:0]  regAddr = 8'h0;
   logic [31:0] regWdata = 32'h0, encoderPosition = 32'h0, regRdata;
   logic [31:0] ramp_actual_position = 32'h0;
   int          failCount = 0, compares = 0;
   always #5 clk = ~clk;
   vlsc_virtual_limit_switch_compare uut (.clk, .srst, .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .encoderPosition,
      .ramp_actual_position, .stopLeft, .stopRight);
   task chk(input logic [31:0] seen, exp, input string s);
      compares++;
      if (seen !== exp) failCount++;
      if (seen !== exp)
         $display("wrong value %s expected %h seen %h", s, exp, seen);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {regWrite, regRead, regAddr, regWdata} <= {w, !w, a, d};
      @(posedge clk) {regWrite, regRead} <= 2'b00;
      #1 if (!w) chk(regRdata, d, "rdata");
   endtask
   task pos(input logic [31:0] e, r, input logic sl, sr);
      @(posedge clk) {encoderPosition, ramp_actual_position} <= {e, r};
      @(posedge clk) #1 chk(stopLeft, sl, "left");
      chk(stopRight, sr, "right");
   endtask
   task rampScene;
      pos(32'h0, 32'h0, 1'b1, 1'b1);
      bus(1'b0, 8'h3f, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      bus(1'b1, 8'h3e, 32'hFFFF_FFFB);
      bus(1'b1, 8'h3f, 32'h0000_0064);
      bus(1'b0, 8'h3e, 32'hFFFF_FFFB);
      pos(32'h0, 32'hFFFF_FFFB, 1'b1, 1'b0);
      pos(32'h8000_0000, 32'h0000_0064, 1'b0, 1'b1);
      pos(32'hFFFF_FFFB, 32'h0, 1'b0, 1'b0);
      $display("ramp source test done");
   endtask
   task encScene;
      bus(1'b1, 8'h40, 32'h0000_0001);
      pos(32'h8000_0000, 32'h0, 1'b1, 1'b0);
      pos(32'h7FFF_FFFF, 32'hFFFF_FFFB, 1'b0, 1'b1);
      pos(32'hFFFF_FFFC, 32'h0000_0064, 1'b0, 1'b0);
      $display("encoder source test done");
   endtask
   task readScene;
      @(posedge clk) {encoderPosition, ramp_actual_position}
         <= {32'h8000_0000, 32'h1234_5678};
      @(posedge clk) {regRead, regAddr} <= {1'b1, 8'h41};
      @(posedge clk) regAddr <= 8'h42;
      #1 chk(regRdata, 32'h0000_0005, "status");
      @(posedge clk) regAddr <= 8'h43;
      #1 chk(regRdata, 32'h8000_0000, "encoder");
      @(posedge clk) regAddr <= 8'h40;
      #1 chk(regRdata, 32'h1234_5678, "ramp");
      @(posedge clk) {regRead, regWrite, regAddr, regWdata}
         <= {2'b01, 8'h3f, 32'h0000_00C8};
      #1 chk(regRdata, 32'h0000_0001, "control");
      @(posedge clk) {regRead, regWrite} <= 2'b10;
      #1 chk(regRdata, 32'h0000_0000, "idle");
      @(posedge clk) regRead <= 1'b0;
      #1 chk(regRdata, 32'h0000_00C8, "right");
      @(posedge clk) #1 chk(regRdata, 32'h0000_0000, "idle");
      $display("register read test done");
   endtask
   task resetScene;
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1 chk(stopLeft, 1'b0, "left");
      chk(stopRight, 1'b0, "right");
      pos(32'h8000_0000, 32'h0000_0064, 1'b0, 1'b1);
      bus(1'b1, 8'hbe, 32'hFFFF_FFFF);
      bus(1'b0, 8'h3e, 32'h0);
      bus(1'b0, 8'h3f, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      $display("reset test done");
   endtask
   task endOfTest;
      $display("compares %0d mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rampScene;
      encScene;
      readScene;
      resetScene;
      endOfTest;
   end
endmodule // vlsc_virtual_limit_switch_compare_bench
`default_nettype wire

/* hdl/vlsc_compare.v */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// signed two-sided limit compare
// ==========================================================================
module vlsc_compare
(
   input  wire signed [31:0] position,
   input  wire signed [31:0] leftLimit,
   input  wire signed [31:0] rightLimit,
   output wire               atLeft,
   output wire               atRight
);

   assign atLeft  = (position <= leftLimit);
   assign atRight = (position >= rightLimit);

endmodule // vlsc_compare

`default_nettype wire

/* hdl/vlsc_defines.vh */
`ifndef VLSC_DEFINES_VH
`define VLSC_DEFINES_VH

// ==========================================================================
// register indices (byte address is four times the index)
// ==========================================================================
`define VLSC_IDX_LEFT       8'h3e
`define VLSC_IDX_RIGHT      8'h3f
`define VLSC_IDX_CTRL       8'h40
`define VLSC_IDX_STATUS     8'h41
`define VLSC_IDX_POSENC     8'h42
`define VLSC_IDX_POSRAMP    8'h43

// ==========================================================================
// field positions
// ==========================================================================
`define VLSC_CTRL_SRC_BIT   0
`define VLSC_STAT_LEFT_BIT  0
`define VLSC_STAT_RIGHT_BIT 1
`define VLSC_STAT_SRC_BIT   2

// ==========================================================================
// reset values
// ==========================================================================
`define VLSC_RST_LEFT       32'h0000_0000
`define VLSC_RST_RIGHT      32'h0000_0000
`define VLSC_RST_SRC        1'h0
`define VLSC_RST_RDATA      32'h0000_0000

`endif

/* hdl/vlsc_virtual_limit_switch_compare.v */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "vlsc_defines.vh"

module vlsc_virtual_limit_switch_compare
(
   input  wire        clk,
   input  wire        srst,
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [31:0] regRdata,
   input  wire [31:0] encoderPosition,
   input  wire [31:0] ramp_actual_position,
   output reg         stopLeft,
   output reg         stopRight
);

   // =======================================================================
   // register select codes
   // =======================================================================
   localparam [2:0] SEL_NONE    = 3'h0;
   localparam [2:0] SEL_LEFT    = 3'h1;
   localparam [2:0] SEL_RIGHT   = 3'h2;
   localparam [2:0] SEL_CTRL    = 3'h3;
   localparam [2:0] SEL_STATUS  = 3'h4;
   localparam [2:0] SEL_POSENC  = 3'h5;
   localparam [2:0] SEL_POSRAMP = 3'h6;

   // =======================================================================
   // address decode, shared by the write and read paths
   // =======================================================================
   function [2:0] decodeIndex;
      input [7:0] index;
      begin
         if (index == `VLSC_IDX_LEFT)
            decodeIndex = SEL_LEFT;
         else if (index == `VLSC_IDX_RIGHT)
            decodeIndex = SEL_RIGHT;
         else if (index == `VLSC_IDX_CTRL)
            decodeIndex = SEL_CTRL;
         else if (index == `VLSC_IDX_STATUS)
            decodeIndex = SEL_STATUS;
         else if (index == `VLSC_IDX_POSENC)
            decodeIndex = SEL_POSENC;
         else if (index == `VLSC_IDX_POSRAMP)
            decodeIndex = SEL_POSRAMP;
         else
            decodeIndex = SEL_NONE;
      end
   endfunction

   // =======================================================================
   // access select
   // =======================================================================
   wire [2:0] writeSel;
   wire [2:0] readSel;
   reg        writeLeft;
   reg        writeRight;
   reg        writeCtrl;

   assign writeSel = regWrite ? decodeIndex(regAddr) : SEL_NONE;
   assign readSel  = regRead  ? decodeIndex(regAddr) : SEL_NONE;

   always @*
   begin
      writeLeft  = 1'b0;
      writeRight = 1'b0;
      writeCtrl  = 1'b0;
      if (writeSel == SEL_LEFT)
      begin
         writeLeft = 1'b1;
      end
      else if (writeSel == SEL_RIGHT)
      begin
         writeRight = 1'b1;
      end
      else if (writeSel == SEL_CTRL)
      begin
         writeCtrl = 1'b1;
      end
   end

   // =======================================================================
   // limit and control registers
   // =======================================================================
   reg [31:0] leftLimit;
   reg [31:0] rightLimit;
   reg        limitSourceEnc;
   reg [31:0] next_leftLimit;
   reg [31:0] next_rightLimit;
   reg        next_limitSourceEnc;

   always @*
   begin
      next_leftLimit = leftLimit;
      if (writeLeft)
      begin
         next_leftLimit = regWdata;
      end
   end

   always @*
   begin
      next_rightLimit = rightLimit;
      if (writeRight)
      begin
         next_rightLimit = regWdata;
      end
   end

   always @*
   begin
      next_limitSourceEnc = limitSourceEnc;
      if (writeCtrl)
      begin
         next_limitSourceEnc = regWdata[`VLSC_CTRL_SRC_BIT];
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         leftLimit <= `VLSC_RST_LEFT;
      end
      else
      begin
         leftLimit <= next_leftLimit;
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         rightLimit <= `VLSC_RST_RIGHT;
      end
      else
      begin
         rightLimit <= next_rightLimit;
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         limitSourceEnc <= `VLSC_RST_SRC;
      end
      else
      begin
         limitSourceEnc <= next_limitSourceEnc;
      end
   end

   // =======================================================================
   // position source select
   // =======================================================================
   reg [31:0] selPosition;

   always @*
   begin
      if (limitSourceEnc)
      begin
         selPosition = encoderPosition;
      end
      else
      begin
         selPosition = ramp_actual_position;
      end
   end

   // =======================================================================
   // signed compare
   // =======================================================================
   wire atLeft;
   wire atRight;

   vlsc_compare u_compare
   (
      .position   (selPosition),
      .leftLimit  (leftLimit),
      .rightLimit (rightLimit),
      .atLeft     (atLeft),
      .atRight    (atRight)
   );

   // =======================================================================
   // stop outputs
   // =======================================================================
   // registered, so a stop trails its cause by one clock
   reg next_stopLeft;
   reg next_stopRight;

   always @*
   begin
      next_stopLeft  = atLeft;
      next_stopRight = atRight;
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         stopLeft <= 1'b0;
      end
      else
      begin
         stopLeft <= next_stopLeft;
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         stopRight <= 1'b0;
      end
      else
      begin
         stopRight <= next_stopRight;
      end
   end

   // =======================================================================
   // readable words
   // =======================================================================
   reg [31:0] ctrlWord;
   reg [31:0] statusWord;

   always @*
   begin
      ctrlWord                     = 32'h0000_0000;
      ctrlWord[`VLSC_CTRL_SRC_BIT] = limitSourceEnc;
   end

   always @*
   begin
      statusWord                       = 32'h0000_0000;
      statusWord[`VLSC_STAT_LEFT_BIT]  = stopLeft;
      statusWord[`VLSC_STAT_RIGHT_BIT] = stopRight;
      statusWord[`VLSC_STAT_SRC_BIT]   = limitSourceEnc;
   end

   // =======================================================================
   // read port
   // =======================================================================
   // data stand for the one cycle after the read strobe, zero otherwise
   reg [31:0] next_regRdata;

   always @*
   begin
      if (readSel == SEL_LEFT)
      begin
         next_regRdata = leftLimit;
      end
      else if (readSel == SEL_RIGHT)
      begin
         next_regRdata = rightLimit;
      end
      else if (readSel == SEL_CTRL)
      begin
         next_regRdata = ctrlWord;
      end
      else if (readSel == SEL_STATUS)
      begin
         next_regRdata = statusWord;
      end
      else if (readSel == SEL_POSENC)
      begin
         next_regRdata = encoderPosition;
      end
      else if (readSel == SEL_POSRAMP)
      begin
         next_regRdata = ramp_actual_position;
      end
      else
      begin
         next_regRdata = `VLSC_RST_RDATA;
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         regRdata <= `VLSC_RST_RDATA;
      end
      else
      begin
         regRdata <= next_regRdata;
      end
   end

endmodule // vlsc_virtual_limit_switch_compare

`default_nettype wire
